// File: logic/afcrm_pkg.sv
// Package: map positions, reset values and encodings of the airflow configuration register bank
`default_nettype none
package afcrm_pkg;
	// ==========================================================
	// Word sizes
	localparam int unsigned AFCRM_DW = 16;                       // Register word width
	localparam int unsigned AFCRM_AW = 16;                       // Map address width

	// ==========================================================
	// Map positions (zero-based register addresses)
	localparam logic [15:0] AFCRM_ADR_SETPOINT_BUS    = 16'h0000; // Bus-written setpoint
	localparam logic [15:0] AFCRM_ADR_SETPOINT_ANALOG = 16'h000C; // Analog setpoint image
	localparam logic [15:0] AFCRM_ADR_SETPOINT_SOURCE = 16'h0076; // Setpoint origin
	localparam logic [15:0] AFCRM_ADR_ROOM_POLARITY   = 16'h0077; // room_pressure_polarity
	localparam logic [15:0] AFCRM_ADR_CASCADE         = 16'h007B; // pressure_cascade_setting
	localparam logic [15:0] AFCRM_ADR_APP_CHOICE      = 16'h007C; // application_choice
	localparam logic [15:0] AFCRM_ADR_ALTITUDE        = 16'h007D; // site_altitude_metres
	localparam logic [15:0] AFCRM_ADR_NOM_DP_SEL      = 16'h007E; // nominal_dp_selected_unit
	localparam logic [15:0] AFCRM_ADR_NOM_DP_PA       = 16'h0080; // nominal_dp_pascal
	localparam logic [15:0] AFCRM_ADR_UNIT_CHOICE     = 16'h0091; // pressure_unit_choice

	// ==========================================================
	// Values after reset
	localparam logic [15:0] AFCRM_RST_SETPOINT_BUS = 16'h0000;
	localparam logic        AFCRM_RST_SOURCE       = 1'b1;        // Bus is the default origin
	localparam logic        AFCRM_RST_POLARITY     = 1'b1;        // Positive pressure
	localparam logic [1:0]  AFCRM_RST_CASCADE      = 2'h0;
	localparam logic [1:0]  AFCRM_RST_APP          = 2'h0;
	localparam logic [15:0] AFCRM_RST_ALTITUDE     = 16'h0000;
	localparam logic [15:0] AFCRM_RST_NOM_DP       = 16'h0000;
	localparam logic [1:0]  AFCRM_RST_UNIT         = 2'h0;

	// ==========================================================
	// Encodings
	localparam logic       AFCRM_SRC_ANALOG   = 1'b0;
	localparam logic       AFCRM_SRC_BUS      = 1'b1;
	localparam logic       AFCRM_POL_NEGATIVE = 1'b0;
	localparam logic       AFCRM_POL_POSITIVE = 1'b1;
	localparam logic [1:0] AFCRM_CASC_OFF     = 2'h0;
	localparam logic [1:0] AFCRM_CASC_ON      = 2'h1;
	localparam logic [1:0] AFCRM_CASC_FAST    = 2'h2;
	localparam logic [1:0] AFCRM_APP_FLOW     = 2'h0;
	localparam logic [1:0] AFCRM_APP_PRESSURE = 2'h1;
	localparam logic [1:0] AFCRM_APP_ROOM     = 2'h2;
	localparam logic [1:0] AFCRM_UNIT_PASCAL  = 2'h0;
	localparam logic [1:0] AFCRM_UNIT_UNUSED  = 2'h1;
	localparam logic [1:0] AFCRM_UNIT_INH2O   = 2'h2;

	// ==========================================================
	// Limits and scaling, in register units
	localparam logic [15:0] AFCRM_ALTITUDE_MAX = 16'h0BB8;        // 3000 m
	localparam logic [15:0] AFCRM_CEIL_SMALL   = 16'h1388;        // 500.0 Pa
	localparam logic [15:0] AFCRM_CEIL_MID     = 16'h1770;        // 600.0 Pa
	localparam logic [15:0] AFCRM_CEIL_ROOM    = 16'h1D4C;        // 750.0 Pa
	localparam logic [15:0] AFCRM_INH2O_MULT   = 16'h0107;        // 65536 / 249.09
	localparam int unsigned AFCRM_INH2O_SHIFT  = 16;
	localparam logic [15:0] AFCRM_DEACTIVATED  = 16'hFFFF;        // Unused or unsupported
	localparam int unsigned AFCRM_RD_CYCLES    = 1;               // Read answer latency

	// ==========================================================
	// Sensor element / product variant
	typedef enum logic [1:0] {
		AFCRM_VAR_SMALL,                                         // 500 Pa element
		AFCRM_VAR_MID,                                           // 600 Pa element
		AFCRM_VAR_ROOM                                           // Room-pressure variant
	} afcrm_variant_e;

	// Smaller of two words, used for every clamp
	function automatic logic [15:0] afcrm_min16(input logic [15:0] a, input logic [15:0] b);
		afcrm_min16 = (a < b) ? a : b;
	endfunction
endpackage
`default_nettype wire

// File: logic/afcrm_regs.sv
// Register bank for setpoint origin, room pressure, cascade, application and nominal pressure
`default_nettype none
module afcrm_regs
	import afcrm_pkg::*;
#(
	parameter afcrm_variant_e VARIANT = AFCRM_VAR_ROOM  // Fitted sensor element
)(
	input  wire logic        mclk_in,                     // System clock
	input  wire logic        srst_in,                     // Synchronous reset
	input  wire logic [15:0] reg_addr_in,                 // Map address
	input  wire logic        reg_wr_in,                   // Write strobe
	input  wire logic [15:0] reg_wdata_in,                // Write data
	input  wire logic        reg_rd_in,                   // Read strobe
	output logic      [15:0] reg_rdata_out,               // Read data
	output logic             reg_rvalid_out,              // Read data valid pulse
	input  wire logic [15:0] analog_setpoint_in,          // Setpoint from analog input
	input  wire logic [1:0]  app_choice_in,               // Application fixed in factory
	input  wire logic [1:0]  cascade_request_in,          // Cascade asked for in factory
	input  wire logic        fast_actuator_in,            // Fast actuator detected
	input  wire logic [15:0] first_sensor_input_in,       // 0-10 V sensor sample
	input  wire logic [15:0] nominal_dp_sensor_in,        // Element nominal pressure
	input  wire logic [15:0] measured_dp_in,              // Measured pressure
	output logic      [15:0] active_setpoint_out,         // Setpoint in force
	output logic             negative_pressure_out,       // Room kept below ambient
	output logic             cascade_active_out,          // Cascade running
	output logic             cascade_fast_out,            // Cascade in fast response
	output logic      [15:0] cascade_input_out,           // Cascade input signal
	output logic      [15:0] pressure_at_nominal_flow_out,// Pressure at nominal flow
	output logic      [15:0] limited_dp_out,              // Measured pressure after clamp
	output logic      [15:0] altitude_out                 // Site altitude in metres
);
	// ==========================================================
	// Storage
	logic [15:0] setpoint_bus_q;       // Bus setpoint
	logic [15:0] setpoint_analog_q;    // Analog setpoint image
	logic        source_q;             // Setpoint origin
	logic        polarity_q;           // Room pressure polarity
	logic [1:0]  cascade_q;            // Cascade setting
	logic [1:0]  cascade_d;            // Next cascade setting
	logic [1:0]  app_q;                // Application choice
	logic [15:0] altitude_q;           // Site altitude
	logic [15:0] nom_pa_q;             // Nominal pressure in 0.1 Pa
	logic [1:0]  unit_q;               // Pressure unit
	logic [15:0] nom_sel;              // Nominal pressure in selected unit
	logic [15:0] rdata_d;              // Next read word
	logic [15:0] rdata_q;              // Read word
	logic        rvalid_q;             // Read answer pulse
	logic [15:0] ceiling;              // Element ceiling
	logic        room_variant;         // Variant has room pressure

	assign room_variant = (VARIANT == AFCRM_VAR_ROOM);

	// Ceiling of the fitted element
	always_comb begin
		case (VARIANT)
			AFCRM_VAR_SMALL: begin
				ceiling = AFCRM_CEIL_SMALL;
			end
			AFCRM_VAR_MID: begin
				ceiling = AFCRM_CEIL_MID;
			end
			default: begin
				ceiling = AFCRM_CEIL_ROOM;
			end
		endcase
	end

	// Write decode helper
	function automatic logic wr_hit(input logic [15:0] adr);
		wr_hit = reg_wr_in && (reg_addr_in == adr);
	endfunction

	// Map decode kept apart from the read mux, so the all-ones check does not restate it
	function automatic logic adr_mapped(input logic [15:0] adr);
		case (adr)
			AFCRM_ADR_SETPOINT_BUS, AFCRM_ADR_SETPOINT_ANALOG, AFCRM_ADR_SETPOINT_SOURCE,
			AFCRM_ADR_ROOM_POLARITY, AFCRM_ADR_CASCADE, AFCRM_ADR_APP_CHOICE, AFCRM_ADR_ALTITUDE,
			AFCRM_ADR_NOM_DP_SEL, AFCRM_ADR_NOM_DP_PA, AFCRM_ADR_UNIT_CHOICE: adr_mapped = 1'b1;
			default:                                                         adr_mapped = 1'b0;
		endcase
	endfunction

	// ==========================================================
	// Writable registers and the read-only analog setpoint image
	// Setpoint origin; only bit 0 carries meaning
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			source_q <= AFCRM_RST_SOURCE;
		end else if (wr_hit(AFCRM_ADR_SETPOINT_SOURCE)) begin
			source_q <= reg_wdata_in[0];
		end
	end

	// Bus setpoint, kept even while analog origin is in force
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			setpoint_bus_q <= AFCRM_RST_SETPOINT_BUS;
		end else if (wr_hit(AFCRM_ADR_SETPOINT_BUS)) begin
			setpoint_bus_q <= reg_wdata_in;
		end
	end

	// Analog setpoint image, refreshed every cycle
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			setpoint_analog_q <= AFCRM_RST_SETPOINT_BUS;
		end else begin
			setpoint_analog_q <= analog_setpoint_in;
		end
	end

	// Polarity; writes on other variants are dropped silently
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			polarity_q <= AFCRM_RST_POLARITY;
		end else if (room_variant && wr_hit(AFCRM_ADR_ROOM_POLARITY)) begin
			polarity_q <= reg_wdata_in[0];
		end
	end

	// Altitude, clamped so the control loop never sees an absurd height
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			altitude_q <= AFCRM_RST_ALTITUDE;
		end else if (wr_hit(AFCRM_ADR_ALTITUDE)) begin
			altitude_q <= afcrm_min16(reg_wdata_in, AFCRM_ALTITUDE_MAX);
		end
	end

	// Unit choice; only pascal and inches of water are accepted
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			unit_q <= AFCRM_RST_UNIT;
		end else if (wr_hit(AFCRM_ADR_UNIT_CHOICE)) begin
			if (reg_wdata_in == 16'(AFCRM_UNIT_PASCAL) || reg_wdata_in == 16'(AFCRM_UNIT_INH2O)) begin
				unit_q <= reg_wdata_in[1:0];
			end
		end
	end

	// ==========================================================
	// Read-only registers
	// Application follows factory setting, never the bus
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			app_q <= AFCRM_RST_APP;
		end else begin
			app_q <= app_choice_in;
		end
	end

	// Cascade permission; a refused fast request falls back to normal
	always_comb begin
		if (app_q != AFCRM_APP_FLOW && app_q != AFCRM_APP_ROOM) begin
			cascade_d = AFCRM_CASC_OFF;
		end else if (cascade_request_in == AFCRM_CASC_FAST) begin
			cascade_d = (room_variant && fast_actuator_in) ? AFCRM_CASC_FAST : AFCRM_CASC_ON;
		end else if (cascade_request_in == AFCRM_CASC_ON) begin
			cascade_d = AFCRM_CASC_ON;
		end else begin
			cascade_d = AFCRM_CASC_OFF;
		end
	end

	// Cascade setting register
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			cascade_q <= AFCRM_RST_CASCADE;
		end else begin
			cascade_q <= cascade_d;
		end
	end

	// Nominal pressure limited by element ceiling
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			nom_pa_q <= AFCRM_RST_NOM_DP;
		end else begin
			nom_pa_q <= afcrm_min16(nominal_dp_sensor_in, ceiling);
		end
	end

	// Selected-unit view of the nominal pressure
	afcrm_unit_conv afcrm_unit_conv_i (
		.mclk_in      (mclk_in),
		.srst_in      (srst_in),
		.pa_tenths_in (nom_pa_q),
		.unit_in      (unit_q),
		.value_out    (nom_sel)
	);

	// ==========================================================
	// Read port, answer one cycle after the strobe
	always_comb begin
		case (reg_addr_in)
			AFCRM_ADR_SETPOINT_BUS:    rdata_d = setpoint_bus_q;
			AFCRM_ADR_SETPOINT_ANALOG: rdata_d = setpoint_analog_q;
			AFCRM_ADR_SETPOINT_SOURCE: rdata_d = {15'h0000, source_q};
			AFCRM_ADR_ROOM_POLARITY:   rdata_d = room_variant ? {15'h0000, polarity_q} : AFCRM_DEACTIVATED;
			AFCRM_ADR_CASCADE:         rdata_d = {14'h0000, cascade_q};
			AFCRM_ADR_APP_CHOICE:      rdata_d = {14'h0000, app_q};
			AFCRM_ADR_ALTITUDE:        rdata_d = altitude_q;
			AFCRM_ADR_NOM_DP_SEL:      rdata_d = nom_sel;
			AFCRM_ADR_NOM_DP_PA:       rdata_d = nom_pa_q;
			AFCRM_ADR_UNIT_CHOICE:     rdata_d = {14'h0000, unit_q};
			default:                   rdata_d = AFCRM_DEACTIVATED;
		endcase
	end

	// Read data register; holds until the next read
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			rdata_q <= 16'h0000;
		end else if (reg_rd_in) begin
			rdata_q <= rdata_d;
		end
	end

	// Read valid pulse
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_rd_in;
		end
	end

	assign reg_rdata_out  = rdata_q;
	assign reg_rvalid_out = rvalid_q;

	// ==========================================================
	// Effects on the control path
	// Setpoint in force follows the origin register
	assign active_setpoint_out = (source_q == AFCRM_SRC_ANALOG) ? setpoint_analog_q
	                                                            : setpoint_bus_q;
	assign negative_pressure_out = (polarity_q == AFCRM_POL_NEGATIVE);
	assign cascade_active_out    = (cascade_q != AFCRM_CASC_OFF);
	assign cascade_fast_out      = (cascade_q == AFCRM_CASC_FAST);
	// Idle cascade input reads zero, so a stale sample cannot steer the loop
	assign cascade_input_out = cascade_active_out ? first_sensor_input_in : 16'h0000;
	// Pressure at nominal flow exists only for flow application
	assign pressure_at_nominal_flow_out = (app_q == AFCRM_APP_FLOW) ? nom_pa_q : 16'h0000;
	// Pressure applications clamp the measurement at the nominal value
	assign limited_dp_out = (app_q == AFCRM_APP_PRESSURE || app_q == AFCRM_APP_ROOM)
	                        ? afcrm_min16(measured_dp_in, nom_pa_q) : measured_dp_in;
	assign altitude_out = altitude_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (srst_in);

	a_source_write: assert property (
		wr_hit(AFCRM_ADR_SETPOINT_SOURCE) |=> source_q == $past(reg_wdata_in[0]))
		else $error("Setpoint origin not stored");

	// Setpoint checks compare against the inputs, not against the mux that they guard
	a_analog_active: assert property (
		source_q == AFCRM_SRC_ANALOG |-> active_setpoint_out == $past(analog_setpoint_in))
		else $error("Analog setpoint not in force");

	a_bus_active: assert property (
		wr_hit(AFCRM_ADR_SETPOINT_BUS) ##1 source_q == AFCRM_SRC_BUS
		|-> active_setpoint_out == $past(reg_wdata_in))
		else $error("Bus setpoint not in force");

	a_polarity_lock: assert property (
		!room_variant |=> polarity_q == AFCRM_POL_POSITIVE)
		else $error("Polarity changed on wrong variant");

	// The lock above is idle on the room variant; this one watches the write itself
	a_polarity_write: assert property (
		room_variant && wr_hit(AFCRM_ADR_ROOM_POLARITY) |=> polarity_q == $past(reg_wdata_in[0]))
		else $error("Polarity write not stored on room variant");

	a_cascade_code: assert property (
		cascade_q != 2'h3)
		else $error("Cascade setting out of range");

	a_cascade_route: assert property (
		cascade_active_out |-> cascade_input_out == first_sensor_input_in)
		else $error("Cascade input not routed");

	a_cascade_permit: assert property (
		(app_q == AFCRM_APP_PRESSURE || app_q == 2'h3) |=> cascade_q == AFCRM_CASC_OFF)
		else $error("Cascade allowed for wrong application");

	a_fast_permit: assert property (
		cascade_q == AFCRM_CASC_FAST |-> room_variant && $past(fast_actuator_in))
		else $error("Fast cascade without fast actuator");

	a_app_readonly: assert property (
		wr_hit(AFCRM_ADR_APP_CHOICE) |=> app_q == $past(app_choice_in))
		else $error("Application changed by bus");

	a_nominal_ceiling: assert property (
		nom_pa_q <= ceiling)
		else $error("Nominal pressure above ceiling");

	a_flow_nominal: assert property (
		app_q == AFCRM_APP_FLOW |-> pressure_at_nominal_flow_out == nom_pa_q)
		else $error("Pressure at nominal flow wrong");

	a_dp_clamp: assert property (
		(app_q == AFCRM_APP_PRESSURE || app_q == AFCRM_APP_ROOM) |-> limited_dp_out <= nom_pa_q)
		else $error("Measured pressure not clamped");

	a_unit_pascal: assert property (
		unit_q == AFCRM_UNIT_PASCAL && $stable(unit_q) |-> nom_sel == $past(nom_pa_q))
		else $error("Pascal view differs from nominal");

	a_unit_legal: assert property (
		unit_q != AFCRM_UNIT_UNUSED && unit_q != 2'h3)
		else $error("Unit choice holds an unused code");

	// A refused unit code must leave the previous choice in place
	a_unit_refused: assert property (
		wr_hit(AFCRM_ADR_UNIT_CHOICE) && reg_wdata_in == 16'(AFCRM_UNIT_UNUSED) |=> $stable(unit_q))
		else $error("Unused unit code was accepted");

	// Any position outside the map, not one chosen address
	a_unmapped_ones: assert property (
		reg_rd_in && !adr_mapped(reg_addr_in)
		|=> reg_rvalid_out && reg_rdata_out == AFCRM_DEACTIVATED)
		else $error("Unused position did not read all ones");

	c_analog_source: cover property (source_q == AFCRM_SRC_ANALOG);
	c_cascade_fast:  cover property (cascade_q == AFCRM_CASC_FAST);
	c_dp_clamped:    cover property (limited_dp_out != measured_dp_in);
	c_negative_room: cover property (negative_pressure_out);
	c_inh2o_read:    cover property (reg_rd_in && reg_addr_in == AFCRM_ADR_NOM_DP_SEL && unit_q == AFCRM_UNIT_INH2O);
endmodule
`default_nettype wire

// File: logic/afcrm_unit_conv.sv
// Converter of the nominal pressure from tenths of pascal into the selected unit
`default_nettype none
module afcrm_unit_conv
	import afcrm_pkg::*;
(
	input  wire logic        mclk_in,      // System clock
	input  wire logic        srst_in,      // Synchronous reset
	input  wire logic [15:0] pa_tenths_in, // Pressure in 0.1 Pa
	input  wire logic [1:0]  unit_in,      // Unit selection
	output logic      [15:0] value_out     // Pressure in 0.1 of the unit
);
	// ==========================================================
	// Arithmetic
	logic [31:0] product;                  // Scaled product for inches of water
	logic [15:0] value_d;                  // Next converted value
	logic [15:0] value_q;                  // Registered converted value

	// Multiply-and-shift avoids a divider; costs about 0.04 % accuracy
	always_comb begin
		product = 32'(pa_tenths_in) * 32'(AFCRM_INH2O_MULT);
		case (unit_in)
			AFCRM_UNIT_PASCAL: begin
				value_d = pa_tenths_in;
			end
			AFCRM_UNIT_INH2O: begin
				value_d = product[31:AFCRM_INH2O_SHIFT];
			end
			default: begin
				value_d = AFCRM_DEACTIVATED;
			end
		endcase
	end

	// Output register, one cycle behind its inputs
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			value_q <= AFCRM_RST_NOM_DP;
		end else begin
			value_q <= value_d;
		end
	end

	assign value_out = value_q;
endmodule
`default_nettype wire

// File: testbench/afcrm_master.sv
// Bus master model that drives the register strobe port of the bank
`default_nettype none
module afcrm_master
	import afcrm_pkg::*;
#(
	parameter int unsigned GAP = 1             // Idle cycles after each request
)(
	input  wire logic        mclk_in,          // System clock
	input  wire logic [15:0] rdata_in,         // Read word from the bank
	input  wire logic        rvalid_in,        // Read valid pulse
	output logic      [15:0] addr_out,         // Map address
	output logic             wr_out,           // Write strobe
	output logic      [15:0] wdata_out,        // Write data
	output logic             rd_out            // Read strobe
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Idle state at time zero
	initial begin
		addr_out = 16'h0000;
		wdata_out = 16'h0000;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end

	// ==========================================================
	// One write; released lines go to the inverse so stale values never pass
	task automatic write(input logic [15:0] a, input logic [15:0] d);
		@(negedge mclk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge mclk_in);
		wr_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
		repeat (GAP) @(negedge mclk_in);
	endtask

	// One read; the answer is awaited under a small bound
	task automatic read(input logic [15:0] a, output logic [15:0] d, output logic ok);
		int n;
		@(negedge mclk_in);
		addr_out = a;
		rd_out = 1'b1;
		@(negedge mclk_in);
		rd_out = 1'b0;
		addr_out = ~a;
		ok = 1'b0;
		d = 16'h0000;
		for (n = 0; n < 4 && !ok; n++) begin
			if (rvalid_in === 1'b1) begin
				ok = 1'b1;
				d = rdata_in;
			end else begin
				@(negedge mclk_in);
			end
		end
		repeat (GAP) @(negedge mclk_in);
	endtask
endmodule
`default_nettype wire

// File: testbench/airflow_config_register_map_bench.sv
// Self-checking bench for the airflow configuration register bank
`default_nettype none
module airflow_config_register_map_bench
	import afcrm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Signals
	logic        mclk_in, srst_in, rvalid, wr, rd, fast, neg, c_act, c_fast;
	logic [15:0] addr, wdata, rdata, analog, sens, nom, meas;
	logic [15:0] act_sp, c_in, pnf, lim, alt;
	logic [1:0]  app, creq;
	int          err_total, cmp_count;

	afcrm_regs afcrm_regs_i (
		.mclk_in(mclk_in), .srst_in(srst_in), .reg_addr_in(addr), .reg_wr_in(wr),
		.reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.analog_setpoint_in(analog), .app_choice_in(app), .cascade_request_in(creq),
		.fast_actuator_in(fast), .first_sensor_input_in(sens), .nominal_dp_sensor_in(nom),
		.measured_dp_in(meas), .active_setpoint_out(act_sp), .negative_pressure_out(neg),
		.cascade_active_out(c_act), .cascade_fast_out(c_fast), .cascade_input_out(c_in),
		.pressure_at_nominal_flow_out(pnf), .limited_dp_out(lim), .altitude_out(alt)
	);

	afcrm_master #(.GAP(1)) afcrm_master_i (
		.mclk_in(mclk_in), .rdata_in(rdata), .rvalid_in(rvalid), .addr_out(addr),
		.wr_out(wr), .wdata_out(wdata), .rd_out(rd)
	);

	// Clock at 50 MHz
	initial begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end

	// ==========================================================
	// Helpers
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// A lost answer counts as a mismatch and ends the run
	task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
		logic [15:0] d;
		logic        ok;
		afcrm_master_i.read(a, d, ok);
		if (ok !== 1'b1) begin
			err_total++;
			end_sim();
		end else chk16(d, exp);
	endtask

	// Status paths lag the factory inputs by up to two cycles
	task automatic idle(input int n);
		repeat (n) @(negedge mclk_in);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		err_total = 0;
		cmp_count = 0;
		srst_in = 1'b1;
		analog = 16'h1234;
		sens = 16'h5A5A;
		nom = 16'h0000;
		meas = 16'h0000;
		app = 2'h0;
		creq = 2'h0;
		fast = 1'b0;
		idle(6);
		srst_in = 1'b0;
		// Reset values
		rdc(16'h0076, 16'h0001);
		rdc(16'h0077, 16'h0001);
		rdc(16'h007B, 16'h0000);
		rdc(16'h007C, 16'h0000);
		rdc(16'h007D, 16'h0000);
		rdc(16'h007E, 16'h0000);
		rdc(16'h0091, 16'h0000);
		// Setpoint origin
		afcrm_master_i.write(16'h0000, 16'h0ABC);
		chk16(act_sp, 16'h0ABC);
		afcrm_master_i.write(16'h0076, 16'h0000);
		rdc(16'h0076, 16'h0000);
		chk16(act_sp, 16'h1234);
		// Polarity, read-only places, unmapped place, altitude clamp
		afcrm_master_i.write(16'h0077, 16'h0000);
		chk16({15'h0000, neg}, 16'h0001);
		rdc(16'h0077, 16'h0000);
		afcrm_master_i.write(16'h007C, 16'h0002);
		rdc(16'h007C, 16'h0000);
		afcrm_master_i.write(16'h007B, 16'h0002);
		rdc(16'h007B, 16'h0000);
		rdc(16'h0078, 16'hFFFF);
		afcrm_master_i.write(16'h007D, 16'h0BB9);
		rdc(16'h007D, 16'h0BB8);
		chk16(alt, 16'h0BB8);
		// Cascade availability
		app = 2'h2;
		creq = 2'h1;
		idle(4);
		rdc(16'h007B, 16'h0001);
		chk16(c_in, 16'h5A5A);
		chk16({15'h0000, c_act}, 16'h0001);
		creq = 2'h2;
		fast = 1'b1;
		idle(4);
		rdc(16'h007B, 16'h0002);
		chk16({15'h0000, c_fast}, 16'h0001);
		fast = 1'b0;
		idle(4);
		rdc(16'h007B, 16'h0001);
		app = 2'h1;
		idle(4);
		rdc(16'h007B, 16'h0000);
		chk16(c_in, 16'h0000);
		chk16({15'h0000, c_act}, 16'h0000);
		// Nominal pressure above the element ceiling
		nom = 16'h2000;
		meas = 16'h3000;
		app = 2'h2;
		idle(4);
		rdc(16'h0080, 16'h1D4C);
		chk16(lim, 16'h1D4C);
		chk16(pnf, 16'h0000);
		meas = 16'h0100;
		idle(1);
		chk16(lim, 16'h0100);
		app = 2'h0;
		meas = 16'h3000;
		idle(4);
		chk16(pnf, 16'h1D4C);
		chk16(lim, 16'h3000);
		// Unit selection
		rdc(16'h007E, 16'h1D4C);
		afcrm_master_i.write(16'h0091, 16'h0002);
		idle(2);
		rdc(16'h007E, 16'h001E);
		afcrm_master_i.write(16'h0091, 16'h0001);
		rdc(16'h0091, 16'h0002);
		end_sim();
	end
endmodule
`default_nettype wire
